// ===== hpb_pkg.sv
// Purpose: Shared constants and carriers for the high-side PWM and bridge setup registers.
// Assumes: 40 MHz system clock; register requests come from the serial frame decoder.
// Notes: Every offset, field position, reset value and timing count lives here.

package hpb_pkg;

  // ==========================================================
  // Clock and PWM timing
  localparam int CLK_HZ = 40_000_000;
  localparam int RATE_SLOW_HZ = 100;
  localparam int RATE_FAST_HZ = 200;
  localparam int DUTY_STEPS = 1024;
  // Longest step time, so rounded down
  localparam int TICK_SLOW_CYC = CLK_HZ / (RATE_SLOW_HZ * DUTY_STEPS);
  localparam int TICK_FAST_CYC = CLK_HZ / (RATE_FAST_HZ * DUTY_STEPS);
  localparam int NUM_GEN = 4;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] ADDR_INT_MASK = 7'h09;
  localparam logic [6:0] ADDR_PWM_SETUP = 7'h0A;
  localparam logic [6:0] ADDR_SCRATCH = 7'h0B;
  localparam logic [6:0] ADDR_BRIDGE = 7'h10;

  // ==========================================================
  // Field positions
  localparam int PWM_RATE_BIT = 14;
  localparam int PWM_DUTY_MSB = 13;
  localparam int PWM_DUTY_LSB = 4;
  localparam int PWM_UNIT_MSB = 2;
  localparam int PWM_UNIT_TOP = 2;
  localparam logic [9:0] DUTY_FULL = 10'h3FF;

  // ==========================================================
  // Reset values and masks
  localparam logic [15:0] INT_MASK_POR = 16'h0140;
  localparam logic [15:0] INT_MASK_RW = 16'h01FF;
  localparam logic [15:0] PWM_SETUP_POR = 16'h0000;
  localparam logic [15:0] PWM_SETUP_RD = 16'h7FF7;
  localparam logic [15:0] PWM_RESTART_KEEP = 16'h7FF0;
  localparam logic [15:0] SCRATCH_POR = 16'h0000;
  localparam logic [15:0] BRIDGE_POR = 16'h0801;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } hpb_req_t;

  typedef struct packed {
    logic rate;
    logic [9:0] duty;
  } hpb_gen_cfg_t;

  typedef struct packed {
    logic bridge_sync_rate;
    logic gen3_route;
    logic gen1_route;
    logic pump_uv_level;
    logic transistor_gate_level;
    logic pump_stage_auto;
    logic overvoltage_recover;
    logic precharge_step_size;
    logic [7:0] low_byte;
  } hpb_bridge_t;

endpackage : hpb_pkg

// ===== hpb_pwm_gen.sv
// Purpose: One high-side PWM generator with 1024 duty steps.
// Assumes: Settings come from flops on the same clock.
// Notes: New settings are taken at a period boundary only.

`timescale 1ns/1ps

module hpb_pwm_gen #(
  parameter int TICK_SLOW = hpb_pkg::TICK_SLOW_CYC,
  parameter int TICK_FAST = hpb_pkg::TICK_FAST_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input hpb_pkg::hpb_gen_cfg_t cfg,
  output logic pwm_q
);

  localparam int PRE_W = $clog2(TICK_SLOW + 1);

  if (TICK_FAST < 1 || TICK_FAST > TICK_SLOW) begin : g_chk
    $error("hpb_pwm_gen: tick counts out of range");
  end

  logic [PRE_W-1:0] pre_q, pre_d, lim;
  logic [9:0] phase_q, phase_d;
  hpb_pkg::hpb_gen_cfg_t act_q, act_d;
  logic pwm_d;

  // ==========================================================
  // Step prescaler and phase counter
  always_comb begin
    // Period timing counts the one system clock
    lim = act_q.rate ? PRE_W'(TICK_FAST - 1) : PRE_W'(TICK_SLOW - 1);
    pre_d = pre_q + PRE_W'(1);
    phase_d = phase_q;
    act_d = act_q;
    if (pre_q >= lim) begin
      pre_d = '0;
      phase_d = phase_q + 10'h001;
      // Reload at the wrap so a running pulse is never cut short
      if (phase_q == hpb_pkg::DUTY_FULL) begin
        act_d = cfg;
      end
    end
    // Zero duty never turns on; full duty never turns off
    pwm_d = (act_q.duty == hpb_pkg::DUTY_FULL) || (phase_q < act_q.duty);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      phase_q <= 10'h000;
      act_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      phase_q <= phase_d;
      act_q <= act_d;
      pwm_q <= pwm_d;
    end
  end

  // ==========================================================
  // Checks
  duty_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    act_q.duty == 10'h000 |=> !pwm_q)
    else $error("zero duty drove the switch on");

endmodule : hpb_pwm_gen

// ===== hpb_setup_regs.sv
// Purpose: PWM setup, host scratch, interrupt mask and bridge setup registers.
// Assumes: Requests arrive from the serial frame decoder on this clock.
// Notes: rst_n is power-on; soft_rst and restart are one-cycle pulses.

`timescale 1ns/1ps

// Function
// - Rate bit selects 100 or 200 Hz.
// - Ten-bit duty at 13:4; zero means off.
// - On-time is duty over 1024; full on.
// - Unit field 2:0 picks generator; 1xx none.
// - Bits 15 and 3 read as zero.
// - Restart keeps 14:4, clears low nibble.
// - First period after configuration may be wrong.
// - Period timing derives from the oscillator.
// - Mask loads 0x0140; restart clears 15:9.
// - Sixteen-bit scratch, untouched by the device.
// - Scratch clears on reset, survives restart.
// - Scratch reachable only in normal mode.
// - Bit 15 selects bridge sync rate.
// - Bit 14 routes generator three.
// - Bit 13 routes generator one.
// - Bit 12 selects pump undervoltage threshold.
// - Bit 11 selects transistor gate level.
// - Bit 10 enables pump stage switchover.
// - Bit 9 enables overvoltage recovery.
// - Bit 8 selects precharge step size.
// - Bridge word loads 0x0801 on reset.
module hpb_setup_regs #(
  parameter int TICK_SLOW = hpb_pkg::TICK_SLOW_CYC,
  parameter int TICK_FAST = hpb_pkg::TICK_FAST_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic restart,
  input wire logic normal_mode,
  input hpb_pkg::hpb_req_t req,
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  output logic [8:0] int_mask_q,
  output hpb_pkg::hpb_bridge_t bridge_cfg_q,
  output logic [3:0] hs_pwm_q,
  output logic [3:0] hb_pwm_q
);

  // A fast step longer than the slow one would invert the rate bit
  if (TICK_FAST < 1 || TICK_FAST > TICK_SLOW) begin : g_chk
    $error("hpb_setup_regs: tick counts out of range");
  end

  // ==========================================================
  // State
  logic [15:0] pwm_setup_q, pwm_setup_d;
  logic [15:0] scratch_q, scratch_d;
  logic [15:0] mask_q, mask_d;
  hpb_pkg::hpb_bridge_t bridge_d;
  hpb_pkg::hpb_gen_cfg_t gen_cfg_q [hpb_pkg::NUM_GEN];
  hpb_pkg::hpb_gen_cfg_t gen_cfg_d [hpb_pkg::NUM_GEN];
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic [3:0] hb_pwm_d;
  logic [3:0] gen_out;

  // ==========================================================
  // Decode
  logic wr_pwm, wr_scr, wr_mask, wr_brg;
  logic [2:0] unit;
  hpb_pkg::hpb_gen_cfg_t new_cfg;

  always_comb begin
    wr_pwm = req.wr && (req.addr == hpb_pkg::ADDR_PWM_SETUP);
    // Outside normal mode the scratch write is dropped
    wr_scr = req.wr && normal_mode && (req.addr == hpb_pkg::ADDR_SCRATCH);
    wr_mask = req.wr && (req.addr == hpb_pkg::ADDR_INT_MASK);
    wr_brg = req.wr && (req.addr == hpb_pkg::ADDR_BRIDGE);
    unit = req.wdata[hpb_pkg::PWM_UNIT_MSB:0];
    new_cfg.rate = req.wdata[hpb_pkg::PWM_RATE_BIT];
    new_cfg.duty = req.wdata[hpb_pkg::PWM_DUTY_MSB:hpb_pkg::PWM_DUTY_LSB];
  end

  // ==========================================================
  // PWM setup register and per-generator settings
  always_comb begin
    pwm_setup_d = pwm_setup_q;
    for (int i = 0; i < hpb_pkg::NUM_GEN; i++) begin
      gen_cfg_d[i] = gen_cfg_q[i];
    end
    if (soft_rst) begin
      pwm_setup_d = hpb_pkg::PWM_SETUP_POR;
    end else if (restart) begin
      // Unit select drops back to the first generator
      pwm_setup_d = pwm_setup_q & hpb_pkg::PWM_RESTART_KEEP;
    end else if (wr_pwm) begin
      pwm_setup_d = req.wdata & hpb_pkg::PWM_SETUP_RD;
      // Only the named unit takes the word; 1xx codes land nowhere
      if (!unit[hpb_pkg::PWM_UNIT_TOP]) begin
        gen_cfg_d[unit[1:0]] = new_cfg;
      end
    end
    if (soft_rst) begin
      for (int i = 0; i < hpb_pkg::NUM_GEN; i++) begin
        gen_cfg_d[i] = '0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_setup_q <= hpb_pkg::PWM_SETUP_POR;
      for (int i = 0; i < hpb_pkg::NUM_GEN; i++) begin
        gen_cfg_q[i] <= '0;
      end
    end else begin
      pwm_setup_q <= pwm_setup_d;
      for (int i = 0; i < hpb_pkg::NUM_GEN; i++) begin
        gen_cfg_q[i] <= gen_cfg_d[i];
      end
    end
  end

  // ==========================================================
  // Host scratch, interrupt mask, bridge setup
  always_comb begin
    scratch_d = scratch_q;
    mask_d = mask_q;
    bridge_d = bridge_cfg_q;
    if (soft_rst) begin
      scratch_d = hpb_pkg::SCRATCH_POR;
      mask_d = hpb_pkg::INT_MASK_POR;
      bridge_d = hpb_pkg::BRIDGE_POR;
    end else if (restart) begin
      // Scratch rides through restart untouched
      mask_d = mask_q & hpb_pkg::INT_MASK_RW;
      // Restart leaves the bridge word undefined; holding it is the cheapest safe value
    end else begin
      if (wr_scr) begin
        scratch_d = req.wdata;
      end
      if (wr_mask) begin
        mask_d = req.wdata & hpb_pkg::INT_MASK_RW;
      end
      if (wr_brg) begin
        bridge_d = req.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scratch_q <= hpb_pkg::SCRATCH_POR;
      mask_q <= hpb_pkg::INT_MASK_POR;
      bridge_cfg_q <= hpb_pkg::BRIDGE_POR;
    end else begin
      scratch_q <= scratch_d;
      mask_q <= mask_d;
      bridge_cfg_q <= bridge_d;
    end
  end

  assign int_mask_q = mask_q[8:0];

  // ==========================================================
  // Read port: answer one cycle after the request
  always_comb begin
    rvalid_d = req.rd;
    rdata_d = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        hpb_pkg::ADDR_INT_MASK: rdata_d = mask_q;
        hpb_pkg::ADDR_PWM_SETUP: rdata_d = pwm_setup_q & hpb_pkg::PWM_SETUP_RD;
        hpb_pkg::ADDR_SCRATCH: rdata_d = normal_mode ? scratch_q : 16'h0000;
        hpb_pkg::ADDR_BRIDGE: rdata_d = bridge_cfg_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================
  // Generators and half-bridge routing
  // The controller is expected to load duty before enabling a switch
  for (genvar g = 0; g < hpb_pkg::NUM_GEN; g++) begin : g_gen
    hpb_pwm_gen #(
      .TICK_SLOW(TICK_SLOW),
      .TICK_FAST(TICK_FAST)
    ) u_gen (
      .clock(clock),
      .rst_n(rst_n),
      .cfg(gen_cfg_q[g]),
      .pwm_q(gen_out[g])
    );
  end

  assign hs_pwm_q = gen_out;

  always_comb begin
    hb_pwm_d = 4'h0;
    hb_pwm_d[0] = gen_out[0] && !bridge_cfg_q.gen1_route;
    hb_pwm_d[1] = gen_out[0] && bridge_cfg_q.gen1_route;
    hb_pwm_d[2] = gen_out[2] && !bridge_cfg_q.gen3_route;
    hb_pwm_d[3] = gen_out[2] && bridge_cfg_q.gen3_route;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hb_pwm_q <= 4'h0;
    end else begin
      hb_pwm_q <= hb_pwm_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  pwm_read_zero_a: assert property (
    $past(req.rd) && $past(req.addr) == hpb_pkg::ADDR_PWM_SETUP |-> !rdata_q[15] && !rdata_q[3])
    else $error("reserved setup bits read nonzero");

  scratch_mode_a: assert property (
    req.wr && !normal_mode && !soft_rst && req.addr == hpb_pkg::ADDR_SCRATCH |=> $stable(scratch_q))
    else $error("scratch changed outside normal mode");

  scratch_write_a: assert property (
    wr_scr && !soft_rst && !restart |=> scratch_q == $past(req.wdata))
    else $error("scratch did not take written value");

  restart_pwm_a: assert property (
    restart && !soft_rst |=> pwm_setup_q[3:0] == 4'h0 && pwm_setup_q[14:4] == $past(pwm_setup_q[14:4]))
    else $error("restart value of setup register wrong");

  restart_mask_a: assert property (
    restart && !soft_rst |=> mask_q[15:9] == 7'h00 && mask_q[8:0] == $past(mask_q[8:0]))
    else $error("restart value of mask register wrong");

  soft_bridge_a: assert property (
    soft_rst |=> bridge_cfg_q == 16'h0801 && mask_q == 16'h0140 && scratch_q == 16'h0000)
    else $error("soft reset values wrong");

  scratch_keep_a: assert property (
    restart && !soft_rst |=> scratch_q == $past(scratch_q))
    else $error("scratch lost across restart");

  unit_none_a: assert property (
    wr_pwm && !soft_rst && !restart && req.wdata[2] |=>
      gen_cfg_q[0] == $past(gen_cfg_q[0]) && gen_cfg_q[1] == $past(gen_cfg_q[1]) &&
      gen_cfg_q[2] == $past(gen_cfg_q[2]) && gen_cfg_q[3] == $past(gen_cfg_q[3]))
    else $error("unit code 1xx changed a generator");

  unit_only_a: assert property (
    wr_pwm && !soft_rst && !restart && req.wdata[2:0] == 3'h1 |=>
      gen_cfg_q[1].duty == $past(req.wdata[13:4]) && gen_cfg_q[0] == $past(gen_cfg_q[0]))
    else $error("setup write reached the wrong generator");

  route_one_a: assert property (
    ##1 hb_pwm_q[1] == ($past(gen_out[0]) && $past(bridge_cfg_q.gen1_route)))
    else $error("generator one routed wrongly");

  route_hb1_a: assert property (
    ##1 hb_pwm_q[0] == ($past(gen_out[0]) && !$past(bridge_cfg_q.gen1_route)))
    else $error("generator one missing on first half-bridge");

  route_three_a: assert property (
    ##1 hb_pwm_q[3] == ($past(gen_out[2]) && $past(bridge_cfg_q.gen3_route)))
    else $error("generator three routed wrongly");

  route_hb3_a: assert property (
    ##1 hb_pwm_q[2] == ($past(gen_out[2]) && !$past(bridge_cfg_q.gen3_route)))
    else $error("generator three missing on third half-bridge");

  pwm_write_rsv_a: assert property (
    wr_pwm && !soft_rst && !restart |=> !pwm_setup_q[15] && !pwm_setup_q[3])
    else $error("reserved setup bits stored");

  soft_pwm_a: assert property (
    soft_rst |=> pwm_setup_q == 16'h0000)
    else $error("soft reset left setup register set");

  soft_gen_a: assert property (
    soft_rst |=> gen_cfg_q[0] == '0 && gen_cfg_q[1] == '0 && gen_cfg_q[2] == '0 && gen_cfg_q[3] == '0)
    else $error("soft reset left generator settings");

  unit_rate_a: assert property (
    wr_pwm && !soft_rst && !restart && req.wdata[2:0] == 3'h0 |=>
      gen_cfg_q[0].rate == $past(req.wdata[14]) && gen_cfg_q[0].duty == $past(req.wdata[13:4]))
    else $error("generator one did not take rate and duty");

  unit_three_a: assert property (
    wr_pwm && !soft_rst && !restart && req.wdata[2:0] == 3'h3 |=>
      gen_cfg_q[3].duty == $past(req.wdata[13:4]) && gen_cfg_q[2] == $past(gen_cfg_q[2]))
    else $error("unit code 3 reached the wrong generator");

  mask_write_a: assert property (
    wr_mask && !soft_rst && !restart |=> mask_q[8:0] == $past(req.wdata[8:0]) && mask_q[15:9] == 7'h00)
    else $error("mask write stored wrong value");

  mask_read_a: assert property (
    req.rd && req.addr == hpb_pkg::ADDR_INT_MASK |=> rvalid_q && rdata_q == $past(mask_q))
    else $error("mask read returned wrong value");

  scratch_read_a: assert property (
    req.rd && normal_mode && req.addr == hpb_pkg::ADDR_SCRATCH |=> rvalid_q && rdata_q == $past(scratch_q))
    else $error("scratch read returned wrong value");

  scratch_hide_a: assert property (
    req.rd && !normal_mode && req.addr == hpb_pkg::ADDR_SCRATCH |=> rdata_q == 16'h0000)
    else $error("scratch visible outside normal mode");

  bridge_write_a: assert property (
    wr_brg && !soft_rst && !restart |=> bridge_cfg_q == $past(req.wdata))
    else $error("bridge word did not take written value");

  restart_bridge_a: assert property (
    restart && !soft_rst |=> bridge_cfg_q == $past(bridge_cfg_q))
    else $error("restart changed bridge word");

  soft_level_a: assert property (
    soft_rst |=> bridge_cfg_q.transistor_gate_level && !bridge_cfg_q.bridge_sync_rate)
    else $error("soft reset gate level or sync rate wrong");

  soft_pump_a: assert property (
    soft_rst |=> !bridge_cfg_q.pump_stage_auto && !bridge_cfg_q.overvoltage_recover)
    else $error("soft reset pump or recovery default wrong");

  soft_uv_a: assert property (
    soft_rst |=> !bridge_cfg_q.pump_uv_level && !bridge_cfg_q.gen1_route && !bridge_cfg_q.gen3_route)
    else $error("soft reset threshold or routing default wrong");

  soft_step_a: assert property (
    soft_rst |=> !bridge_cfg_q.precharge_step_size)
    else $error("soft reset step size default wrong");

endmodule : hpb_setup_regs

// ===== hpb_host_model.sv
// Purpose: Controller-side model that issues register requests to the setup registers.
// Assumes: Requests change at the falling edge only; one transfer per call.
// Notes: Released requests clear wr and rd and carry inverted address and data so stale data never looks live.

`timescale 1ns/1ps

module hpb_host_model (
  input wire logic clock,
  output hpb_pkg::hpb_req_t req,
  input wire logic [15:0] rdata_q,
  input wire logic rvalid_q
);
  // ==========================================================
  // Request transfer
  initial req = '0;

  // Duty is always written before the generator is used
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rd_data, output logic rd_ok);
    @(negedge clock);
    req = {wr, ~wr, addr, wdata};
    @(negedge clock);
    rd_data = rdata_q;
    rd_ok = rvalid_q;
    req = {2'b00, ~addr, ~wdata};
  endtask : xfer
endmodule : hpb_host_model

// ===== hpb_setup_regs_test.sv
// Purpose: Self-checking bench for the PWM, scratch, mask and bridge setup registers.
// Assumes: Shortened step counts; inputs change at the falling edge.
// Notes: Duty is measured as high cycles over whole periods, so phase does not matter.

`timescale 1ns/1ps

module hpb_setup_regs_test;
  localparam int TS = 4;
  localparam int TF = 2;
  localparam int PS = 1024 * TS;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  logic normal_mode = 1'b1;
  hpb_pkg::hpb_req_t req;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [8:0] int_mask_q;
  hpb_pkg::hpb_bridge_t bridge_cfg_q;
  logic [3:0] hs_pwm_q;
  logic [3:0] hb_pwm_q;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cnt [8];
  logic [31:0] seed = 32'h0000001C;
  logic [15:0] v;
  logic [15:0] sc;
  logic [15:0] pw;
  logic [15:0] br;
  logic [9:0] d1;
  logic [9:0] d2;

  always #12.5 clock = ~clock;

  hpb_setup_regs #(.TICK_SLOW(TS), .TICK_FAST(TF)) i_dut (.clock(clock), .rst_n(rst_n),
    .soft_rst(soft_rst), .restart(restart), .normal_mode(normal_mode), .req(req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .int_mask_q(int_mask_q),
    .bridge_cfg_q(bridge_cfg_q), .hs_pwm_q(hs_pwm_q), .hb_pwm_q(hb_pwm_q));

  hpb_host_model i_host (.clock(clock), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chkcnt(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkcnt

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    logic ok;
    i_host.xfer(1'b1, a, d, x, ok);
    chk16({15'h0000, ok}, 16'h0000);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] x;
    logic ok;
    i_host.xfer(1'b0, a, 16'h0000, x, ok);
    chk16({15'h0000, ok}, 16'h0001);
    chk16(x, exp);
  endtask : rdc

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask : pulse

  task automatic measure(input int n);
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    repeat (n) begin
      @(negedge clock);
      chkcnt(32'($isunknown({hs_pwm_q, hb_pwm_q})), 32'h0);
      for (int i = 0; i < 4; i++) begin
        cnt[i] += hs_pwm_q[i];
        cnt[i + 4] += hb_pwm_q[i];
      end
    end
  endtask : measure

  // Guards against a hang in any wait below
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    chk16({7'h00, int_mask_q}, 16'h0140);
    chk16(bridge_cfg_q, 16'h0801);
    rdc(hpb_pkg::ADDR_PWM_SETUP, 16'h0000);
    rdc(hpb_pkg::ADDR_SCRATCH, 16'h0000);
    rdc(hpb_pkg::ADDR_BRIDGE, 16'h0801);
    rdc(hpb_pkg::ADDR_INT_MASK, 16'h0140);
    rdc(7'h7F, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      pw = 16'(xs());
      sc = 16'(xs());
      br = 16'(xs());
      wr(hpb_pkg::ADDR_PWM_SETUP, pw);
      rdc(hpb_pkg::ADDR_PWM_SETUP, {1'b0, pw[14:4], 1'b0, pw[2:0]});
      wr(hpb_pkg::ADDR_SCRATCH, sc);
      rdc(hpb_pkg::ADDR_SCRATCH, sc);
      wr(hpb_pkg::ADDR_BRIDGE, br);
      rdc(hpb_pkg::ADDR_BRIDGE, br);
      chk16(bridge_cfg_q, br);
    end
    wr(hpb_pkg::ADDR_INT_MASK, 16'hFFFF);
    pulse(restart);
    rdc(hpb_pkg::ADDR_PWM_SETUP, {1'b0, pw[14:4], 4'h0});
    rdc(hpb_pkg::ADDR_SCRATCH, sc);
    rdc(hpb_pkg::ADDR_INT_MASK, 16'h01FF);
    normal_mode = 1'b0;
    wr(hpb_pkg::ADDR_SCRATCH, ~sc);
    rdc(hpb_pkg::ADDR_SCRATCH, 16'h0000);
    normal_mode = 1'b1;
    rdc(hpb_pkg::ADDR_SCRATCH, sc);
    pulse(soft_rst);
    rdc(hpb_pkg::ADDR_PWM_SETUP, 16'h0000);
    rdc(hpb_pkg::ADDR_SCRATCH, 16'h0000);
    rdc(hpb_pkg::ADDR_INT_MASK, 16'h0140);
    rdc(hpb_pkg::ADDR_BRIDGE, 16'h0801);
    // Odd duties from 1 to 511 so neither end case hides a scaling slip
    v = 16'(xs());
    d1 = {1'b0, v[8:1], 1'b1};
    v = 16'(xs());
    d2 = {1'b0, v[8:1], 1'b1};
    wr(hpb_pkg::ADDR_PWM_SETUP, {2'b00, d1, 4'h0});
    wr(hpb_pkg::ADDR_PWM_SETUP, {2'b01, d2, 4'h1});
    wr(hpb_pkg::ADDR_PWM_SETUP, {2'b00, 10'h3FF, 4'h2});
    wr(hpb_pkg::ADDR_PWM_SETUP, {2'b00, 10'h000, 4'h3});
    repeat (3 * PS) @(negedge clock);
    measure(PS);
    chkcnt(cnt[0], int'(d1) * TS);
    chkcnt(cnt[2], PS);
    chkcnt(cnt[3], 0);
    chkcnt(cnt[4], int'(d1) * TS);
    chkcnt(cnt[6], PS);
    measure(1024 * TF);
    chkcnt(cnt[1], int'(d2) * TF);
    wr(hpb_pkg::ADDR_PWM_SETUP, {2'b01, 10'h3FF, 4'h4});
    wr(hpb_pkg::ADDR_BRIDGE, 16'h6801);
    repeat (2 * PS) @(negedge clock);
    measure(PS);
    chkcnt(cnt[0], int'(d1) * TS);
    chkcnt(cnt[1], 2 * int'(d2) * TF);
    chkcnt(cnt[3], 0);
    chkcnt(cnt[5], int'(d1) * TS);
    chkcnt(cnt[7], PS);
    report_and_stop();
  end
endmodule : hpb_setup_regs_test
